// ### hw/tcc_timer.sv
// Operation
// - continuous mode counts to ffff, wraps to zero; channel 0 acts as others
// - continuous mode sets rollover flag on counted step ffff to zero
// - up/down mode counts zero to period and back; period twice period value
// - up/down direction is latched and kept across stop
// - clear bit zeroes direction and count value
// - up/down: channel 0 flag on period-1 to period, rollover on 1 to 0
// - period write while descending: register now, shadow and new period after zero
// - period write while ascending: count up to new period if reachable
// - new period below count while ascending: start down, maybe one extra
// - compare registers unbuffered; no hardware dead time
// - three capture/compare channels, identical except channel 0
// - snapshot bit one selects capture; input select picks source
// - edge select picks rising, falling or both edges
// - capture copies count into channel register and sets event flag
// - input level bit shows selected input level
// - synchronize bit defers capture to next timer clock edge
// - overrun set on capture before previous read; only software clears
// - snapshot zero is compare; match sets flag, pulse, drive, latched input
// - eight drive modes from own and period match; clocked except mode 0
// - modes 000 direct, 001 set, 101 reset, 100 toggle
// - modes 010 tgl/rst, 011 set/rst, 110 tgl/set, 111 rst/set
// - software loading the count triggers no match action
// - mode field 00 stop, 01 up, 10 continuous, 11 up/down
// - count steps once per timer clock per mode and direction
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [3:0]            regAddr,
  input  wire logic [15:0]           regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [15:0]           regRdData,
  input  wire logic [tcc_pkg::CH_NUM-1:0] captureInputA,
  input  wire logic [tcc_pkg::CH_NUM-1:0] captureInputB,
  output logic      [tcc_pkg::CH_NUM-1:0] unitDriveSignal,
  output logic      [tcc_pkg::CH_NUM-1:0] channelIrq,
  output logic                       rolloverIrq
);
  import tcc_pkg::*;

  function automatic logic [3:0] cctlAddr(input int i);
    cctlAddr = A_CCTL0 + 4'(i);
  endfunction : cctlAddr

  function automatic logic [3:0] ccrAddr(input int i);
    ccrAddr = A_CCR0 + 4'(i);
  endfunction : ccrAddr

  logic [1:0]  countModeField;
  logic        rollIe;
  logic        rolloverFlag;
  logic [15:0] countValue;
  logic        countDown;
  logic [15:0] periodShadow;
  logic [15:0] ccr      [CH_NUM];
  logic [15:0] cctl     [CH_NUM];
  logic [CH_NUM-1:0] aSync1, aSync2, bSync1, bSync2;
  logic [CH_NUM-1:0] selPrev;
  logic [CH_NUM-1:0] capPend;
  logic [CH_NUM-1:0] unreadCap;
  logic [15:0] rdMux;

  wire tcc_mode_t modeNow    = tcc_mode_t'(countModeField);
  wire       wrCtrl          = regWr && (regAddr == A_CTRL);
  wire       wrCount         = regWr && (regAddr == A_COUNT);
  wire       clearCmd        = wrCtrl && regWrData[B_CLEAR];
  wire       wrPeriod        = regWr && (regAddr == ccrAddr(0));
  wire [15:0] period         = ccr[0];
  // new period reachable from below; else reverse early
  wire       upPastPeriod    = countValue >= periodShadow;
  wire       running         = (modeNow != TCC_STOP);

  // next count and direction, combinational
  logic [15:0] nextCount;
  logic        nextDown;
  logic        stepped;
  always_comb begin
    nextCount = countValue;
    nextDown  = countDown;
    stepped   = 1'b0;
    case (modeNow)
      TCC_STOP: begin
        nextCount = countValue;
      end
      TCC_UP: begin
        stepped   = 1'b1;
        nextCount = (countValue >= period) ? CNT_ZERO : countValue + CNT_ONE;
      end
      TCC_CONT: begin
        stepped   = 1'b1;
        nextCount = countValue + CNT_ONE;
      end
      TCC_UPDN: begin
        stepped = 1'b1;
        if (!countDown) begin
          if (upPastPeriod) begin
            nextDown  = 1'b1;
            nextCount = countValue - CNT_ONE;
          end else begin
            nextCount = countValue + CNT_ONE;
          end
        end else if (countValue == CNT_ZERO) begin
          nextDown  = 1'b0;
          nextCount = CNT_ONE;
        end else begin
          nextCount = countValue - CNT_ONE;
        end
      end
      default: begin
        nextCount = countValue;
      end
    endcase
  end

  // a counted step only; software loads and clears never count
  wire countStep = stepped && !wrCount && !clearCmd;
  wire rollEvent = countStep && (
                     (modeNow == TCC_CONT && countValue == CNT_MAX) ||
                     (modeNow == TCC_UP && nextCount == CNT_ZERO &&
                      countValue != CNT_ZERO) ||
                     (modeNow == TCC_UPDN && countDown &&
                      countValue == CNT_ONE));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      countValue <= CNT_ZERO;
      countDown  <= 1'b0;
    end else if (clearCmd) begin
      countValue <= CNT_ZERO;
      countDown  <= 1'b0;
    end else if (wrCount) begin
      countValue <= regWrData;
    end else if (countStep) begin
      countValue <= nextCount;
      countDown  <= nextDown;
    end
  end

  // shadow follows writes at once except when descending; then it loads only at zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periodShadow <= CNT_ZERO;
    end else if (modeNow != TCC_UPDN || !countDown) begin
      periodShadow <= wrPeriod ? regWrData : period;
    end else if (countValue == CNT_ZERO) begin
      periodShadow <= period;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      countModeField <= 2'b00;
      rollIe         <= 1'b0;
    end else if (wrCtrl) begin
      countModeField <= regWrData[B_MODE_LO+1:B_MODE_LO];
      rollIe         <= regWrData[B_ROLLIE];
    end
  end

  // hardware set wins over software clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rolloverFlag <= 1'b0;
    end else if (rollEvent) begin
      rolloverFlag <= 1'b1;
    end else if (wrCtrl) begin
      rolloverFlag <= regWrData[B_ROLLFLAG];
    end
  end

  // period match: in up/down only on the upward arrival
  wire periodMatch = countStep && (nextCount == period) &&
                     (modeNow != TCC_UPDN || !countDown);

  genvar g;
  generate
    for (g = 0; g < CH_NUM; g++) begin : gCh
      wire        snap     = cctl[g][B_SNAP];
      wire [1:0]  edgeSel  = cctl[g][B_EDGE_HI:B_EDGE_LO];
      wire [1:0]  srcSel   = cctl[g][B_SEL_HI:B_SEL_LO];
      wire tcc_dmode_t dmode = tcc_dmode_t'(cctl[g][B_DMODE_LO+2:B_DMODE_LO]);
      // select high forces a supply level for software capture
      wire        selIn    = srcSel[1] ? srcSel[0] :
                             (srcSel[0] ? bSync2[g] : aSync2[g]);
      wire        rise     = selIn && !selPrev[g];
      wire        fall     = !selIn && selPrev[g];
      wire        edgeHit  = snap && (((edgeSel & EDGE_RISE) != 2'b00 && rise) ||
                             ((edgeSel & EDGE_FALL) != 2'b00 && fall));
      wire        capNow   = cctl[g][B_SYNC] ? capPend[g] : edgeHit;
      wire        matchPulse = !snap && countStep &&
                               (nextCount == ccr[g]);
      wire        pm       = periodMatch;
      wire        wrCtl    = regWr && (regAddr == cctlAddr(g));
      wire        wrCcr    = regWr && (regAddr == ccrAddr(g));
      wire        rdCcr    = regRd && (regAddr == ccrAddr(g));
      logic       nextDrive;
      logic       driveReg;

      always_comb begin
        nextDrive = cctl[g][B_DRIVE];
        case (dmode)
          DM_OUT:    nextDrive = cctl[g][B_DRIVE];
          DM_SET:    nextDrive = matchPulse ? 1'b1 : unitDriveSignal[g];
          DM_TGLRST: nextDrive = pm ? 1'b0 :
                                 (matchPulse ? !unitDriveSignal[g] :
                                  unitDriveSignal[g]);
          DM_SETRST: nextDrive = pm ? 1'b0 :
                                 (matchPulse ? 1'b1 : unitDriveSignal[g]);
          DM_TGL:    nextDrive = matchPulse ? !unitDriveSignal[g] :
                                 unitDriveSignal[g];
          DM_RST:    nextDrive = matchPulse ? 1'b0 : unitDriveSignal[g];
          DM_TGLSET: nextDrive = pm ? 1'b1 :
                                 (matchPulse ? !unitDriveSignal[g] :
                                  unitDriveSignal[g]);
          DM_RSTSET: nextDrive = pm ? 1'b1 :
                                 (matchPulse ? 1'b0 : unitDriveSignal[g]);
          default:   nextDrive = unitDriveSignal[g];
        endcase
      end

      // mode 0 follows the control bit with no clock
      assign unitDriveSignal[g] = (dmode == DM_OUT) ? cctl[g][B_DRIVE] :
                                  driveReg;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) driveReg <= 1'b0;
        else         driveReg <= nextDrive;
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          aSync1[g]  <= 1'b0;
          aSync2[g]  <= 1'b0;
          bSync1[g]  <= 1'b0;
          bSync2[g]  <= 1'b0;
          selPrev[g] <= 1'b0;
          capPend[g] <= 1'b0;
        end else begin
          aSync1[g]  <= captureInputA[g];
          aSync2[g]  <= aSync1[g];
          bSync1[g]  <= captureInputB[g];
          bSync2[g]  <= bSync1[g];
          selPrev[g] <= selIn;
          capPend[g] <= edgeHit;
        end
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ccr[g] <= CNT_ZERO;
        end else if (snap && capNow) begin
          ccr[g] <= countValue;
        end else if (wrCcr) begin
          ccr[g] <= regWrData;
        end
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          unreadCap[g] <= 1'b0;
        end else if (snap && capNow) begin
          unreadCap[g] <= 1'b1;
        end else if (rdCcr) begin
          unreadCap[g] <= 1'b0;
        end
      end

      // control word; events override software for flag bits
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cctl[g] <= 16'h0000;
        end else begin
          if (wrCtl) begin
            cctl[g] <= regWrData;
          end
          cctl[g][B_LEVEL] <= selIn;
          if (matchPulse) begin
            cctl[g][B_LATIN] <= selIn;
          end else if (wrCtl) begin
            cctl[g][B_LATIN] <= cctl[g][B_LATIN];
          end
          if ((snap && capNow) || matchPulse) begin
            cctl[g][B_EVT] <= 1'b1;
          end else if (g == 0 && periodMatch && modeNow != TCC_CONT &&
                       snap) begin
            cctl[g][B_EVT] <= 1'b1;
          end
          if (snap && capNow && unreadCap[g]) begin
            cctl[g][B_OVR] <= 1'b1;
          end
        end
      end

      assign channelIrq[g] = cctl[g][B_EVT] && cctl[g][B_IE];
    end
  endgenerate

  assign rolloverIrq = rolloverFlag && rollIe;

  always_comb begin
    rdMux = 16'h0000;
    if (regAddr == A_CTRL) begin
      rdMux = 16'h0000;
      rdMux[B_MODE_LO+1:B_MODE_LO] = countModeField;
      rdMux[B_ROLLIE]   = rollIe;
      rdMux[B_ROLLFLAG] = rolloverFlag;
    end else if (regAddr == A_COUNT) begin
      rdMux = countValue;
    end
    for (int i = 0; i < CH_NUM; i++) begin
      if (regAddr == cctlAddr(i)) rdMux = cctl[i];
      if (regAddr == ccrAddr(i))  rdMux = ccr[i];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)    regRdData <= 16'h0000;
    else if (regRd) regRdData <= rdMux;
    else            regRdData <= 16'h0000;
  end
endmodule : tcc_timer
`default_nettype wire

// ### inc/tcc_pkg.sv
package tcc_pkg;
  localparam int          CH_NUM     = 3;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;

  // register index map (word addresses)
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_COUNT  = 4'h1;
  localparam logic [3:0] A_CCTL0  = 4'h2;
  localparam logic [3:0] A_CCR0   = 4'h5;

  // control register bits
  localparam int B_MODE_LO  = 4;
  localparam int B_CLEAR    = 2;
  localparam int B_ROLLIE   = 1;
  localparam int B_ROLLFLAG = 0;

  // channel control bits
  localparam int B_EDGE_HI  = 15;
  localparam int B_EDGE_LO  = 14;
  localparam int B_SEL_HI   = 13;
  localparam int B_SEL_LO   = 12;
  localparam int B_SYNC     = 11;
  localparam int B_LATIN    = 10;
  localparam int B_SNAP     = 8;
  localparam int B_DMODE_LO = 5;
  localparam int B_IE       = 4;
  localparam int B_LEVEL    = 3;
  localparam int B_DRIVE    = 2;
  localparam int B_OVR      = 1;
  localparam int B_EVT      = 0;

  typedef enum logic [1:0] {
    TCC_STOP = 2'b00,
    TCC_UP   = 2'b01,
    TCC_CONT = 2'b10,
    TCC_UPDN = 2'b11
  } tcc_mode_t;

  typedef enum logic [2:0] {
    DM_OUT    = 3'b000,
    DM_SET    = 3'b001,
    DM_TGLRST = 3'b010,
    DM_SETRST = 3'b011,
    DM_TGL    = 3'b100,
    DM_RST    = 3'b101,
    DM_TGLSET = 3'b110,
    DM_RSTSET = 3'b111
  } tcc_dmode_t;

  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
endpackage : tcc_pkg

// ### tb/tcc_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_chk (
  input wire logic [3:0]                 regAddr,
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic [15:0]                regWrData,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [15:0]                regRdData,
  input wire logic [tcc_pkg::CH_NUM-1:0] unitDriveSignal,
  input wire logic [tcc_pkg::CH_NUM-1:0] channelIrq,
  input wire logic                       rolloverIrq
);
  import tcc_pkg::*;
  logic ctlWr;
  logic cc0Wr;
  logic cc1Wr;
  assign ctlWr = regWr && regAddr == A_CTRL;
  assign cc0Wr = regWr && regAddr == A_CCTL0;
  assign cc1Wr = regWr && regAddr == A_CCTL0 + 4'h1;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_rd_idle: assert property (!regRd |=> regRdData == 16'h0000)
    else $error("read data outside read slot");
  a_rd_unmapped: assert property (regRd && regAddr > 4'h7 |=> !regRdData)
    else $error("unmapped read not zero");
  a_mode0_direct: assert property (
    cc0Wr && regWrData[7:5] == 3'h0
    |=> unitDriveSignal[0] == $past(regWrData[B_DRIVE]))
    else $error("mode 0 output not direct");
  a_clear_count: assert property (
    ctlWr && regWrData[B_CLEAR] && regWrData[5:4] == 2'h0 ##1 !regWr
    ##1 regRd && regAddr == A_COUNT |=> regRdData == CNT_ZERO)
    else $error("count not cleared");
  a_roll_mask: assert property (ctlWr && !regWrData[B_ROLLIE] |=> !rolloverIrq)
    else $error("rollover request while disabled");
  a_roll_set: assert property (ctlWr && regWrData[1:0] == 2'b11 |=> rolloverIrq)
    else $error("rollover flag not set by write");
  a_roll_hold: assert property (rolloverIrq && !ctlWr |=> rolloverIrq)
    else $error("rollover request dropped");
  a_ch_mask: assert property (cc0Wr && !regWrData[B_IE] |=> !channelIrq[0])
    else $error("channel request while disabled");
  a_ch_set: assert property (
    cc0Wr && regWrData[B_IE] && regWrData[B_EVT] |=> channelIrq[0])
    else $error("channel flag not set by write");
  a_ch_hold: assert property (channelIrq[1] && !cc1Wr |=> channelIrq[1])
    else $error("channel request dropped");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !regRdData
    && !channelIrq && !rolloverIrq && !unitDriveSignal)
    else $error("outputs active out of reset");
endmodule : tcc_timer_chk
bind tcc_timer tcc_timer_chk chk (.sys_clk, .sys_rst, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .unitDriveSignal, .channelIrq, .rolloverIrq);
`default_nettype wire

// ### tb/tcc_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
  input  wire logic [tcc_pkg::CH_NUM-1:0] sys_clk_unused,
  input  wire logic                       sys_clk,
  input  wire logic [tcc_pkg::CH_NUM-1:0] pinLevel,
  input  wire logic [tcc_pkg::CH_NUM-1:0] unitDriveSignal,
  output var  logic [tcc_pkg::CH_NUM-1:0] captureInputA,
  output var  logic [tcc_pkg::CH_NUM-1:0] captureInputB,
  output var  int                         edgeGap
);
  import tcc_pkg::*;
  int   cnt;
  logic lastDrive;
  initial begin
    captureInputA = '0;
    captureInputB = '1;
    edgeGap = 0;
    cnt = 0;
    lastDrive = 1'b0;
  end
  // pins move just after the edge, as a board driver would
  always @(posedge sys_clk) begin
    captureInputA <= pinLevel;
    captureInputB <= ~pinLevel;
    lastDrive <= unitDriveSignal[0];
    cnt <= cnt + 1;
    // cycles between flips of output 0
    if (unitDriveSignal[0] !== lastDrive) begin
      edgeGap <= cnt;
      cnt <= 1;
    end
  end
endmodule : tcc_pins
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  logic              sys_clk;
  logic              sys_rst;
  logic [3:0]        regAddr;
  logic [15:0]       regWrData;
  logic              regWr;
  logic              regRd;
  logic [15:0]       regRdData;
  logic [CH_NUM-1:0] pinLevel;
  logic [CH_NUM-1:0] captureInputA;
  logic [CH_NUM-1:0] captureInputB;
  logic [CH_NUM-1:0] unitDriveSignal;
  logic [CH_NUM-1:0] channelIrq;
  logic              rolloverIrq;
  int                edgeGap;
  int                miscompares;
  int                checksDone;
  logic [15:0]       d;
  logic [15:0]       n;

  tcc_timer dut (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .captureInputA, .captureInputB, .unitDriveSignal,
    .channelIrq, .rolloverIrq);
  tcc_pins pins (.sys_clk_unused(), .sys_clk, .pinLevel, .unitDriveSignal,
    .captureInputA, .captureInputB, .edgeGap);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic t_regs;
    rd(A_COUNT, d);
    chk("count reset", d, 16'h0000);
    wr(4'h9, 16'h1234);
    rd(4'h9, d);
    chk("unmapped", d, 16'h0000);
    wr(A_CTRL, 16'h0003);
    #1 chk("roll set", {15'h0, rolloverIrq}, 16'h0001);
    wr(A_CCTL0, 16'h0015);
    #1 chk("ch set", {15'h0, channelIrq[0]}, 16'h0001);
    wr(A_CCTL0, 16'h0000);
    wr(A_CTRL, 16'h0000);
  endtask : t_regs

  task automatic t_cont;
    int i;
    wr(A_COUNT, 16'hffff);
    wr(A_CTRL, 16'h0002);
    #1 chk("loaded max", {15'h0, rolloverIrq}, 16'h0000);
    wr(A_COUNT, 16'hfffd);
    wr(A_CTRL, 16'h0022);
    for (i = 0; i < 8 && rolloverIrq !== 1'b1; i++)
      cyc(1);
    chk("wrap step", 16'(i), 16'h0003);
    rd(A_COUNT, n);
    chk("wrapped", {15'h0, n < 16'h0010}, 16'h0001);
    wr(A_CTRL, 16'h0004);
    rd(A_COUNT, n);
    chk("cleared", n, 16'h0000);
  endtask : t_cont

  task automatic t_updn;
    int tc;
    int tr;
    tc = -1;
    tr = -1;
    wr(A_CCR0, 16'h0004);
    wr(A_CCTL0, 16'h0090);
    wr(A_CTRL, 16'h0032);
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (channelIrq[0] === 1'b1 && tc < 0) tc = i;
      if (rolloverIrq === 1'b1 && tr < 0) tr = i;
    end
    chk("flag spacing", 16'(tr - tc), 16'h0004);
    chk("period", 16'(edgeGap), 16'h0008);
  endtask : t_updn

  task automatic t_modes;
    logic [2:0] g;
    logic       p;
    // levels after period match, mid-period, after the up match
    logic [2:0] e [8] = '{3'h0, 3'h7, 3'h2, 3'h3, 3'h0, 3'h0, 3'h5, 3'h4};
    wr(A_CCR0 + 4'h1, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      wr(A_CCTL0 + 4'h1, {8'h00, 3'(i), 5'h00});
      cyc(10);
      p = unitDriveSignal[0];
      for (int j = 0; j < 12 && unitDriveSignal[0] === p; j++)
        cyc(1);
      g[2] = unitDriveSignal[1];
      cyc(4);
      g[1] = unitDriveSignal[1];
      cyc(3);
      g[0] = unitDriveSignal[1];
      if (i == 4)
        chk("toggle", {14'h0, g[2] ^ g[1], g[2] ^ g[0]}, 16'h0002);
      else
        chk("drive mode", {13'h0, g}, {13'h0, e[i]});
    end
  endtask : t_modes

  task automatic t_capture;
    wr(A_CTRL, 16'h0020);
    wr(A_CCTL0 + 4'h1, 16'h4910);
    pinLevel[1] <= 1'b1;
    for (int i = 0; i < 10 && channelIrq[1] !== 1'b1; i++)
      cyc(1);
    rd(A_CCTL0 + 4'h1, d);
    chk("level", {15'h0, d[B_LEVEL]}, 16'h0001);
    rd(A_CCR0 + 4'h1, d);
    rd(A_COUNT, n);
    chk("snapshot", {15'h0, 16'(n - d) inside {[1:15]}}, 16'h0001);
    wr(A_CCTL0 + 4'h1, 16'h4910);
    pinLevel[1] <= 1'b0;
    cyc(8);
    chk("fall ignored", {15'h0, channelIrq[1]}, 16'h0000);
    pinLevel[1] <= 1'b1;
    cyc(6);
    pinLevel[1] <= 1'b0;
    cyc(6);
    pinLevel[1] <= 1'b1;
    cyc(6);
    rd(A_CCR0 + 4'h1, d);
    rd(A_CCTL0 + 4'h1, d);
    chk("overrun", d[1:0], 16'h0003);
    wr(A_CCTL0 + 4'h1, 16'h4900);
    rd(A_CCTL0 + 4'h1, d);
    chk("overrun clr", {15'h0, d[B_OVR]}, 16'h0000);
    wr(A_CCTL0 + 4'h2, 16'he900);
    wr(A_CCTL0 + 4'h2, 16'hf900);
    cyc(4);
    rd(A_CCTL0 + 4'h2, d);
    chk("soft capture", {14'h0, d[B_LEVEL], d[B_EVT]}, 16'h0003);
  endtask : t_capture

  initial begin
    sys_rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    pinLevel = '0;
    miscompares = 0;
    checksDone = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_cont();
    t_updn();
    t_modes();
    t_capture();
    stop_test();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200us;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
